// ==== logic/rx_sof_sync_correlator_config.sv ====
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module rx_sof_sync_correlator_config
    import rx_cfg_pkg::*;
#(
    parameter logic [7:0] TRIM_BOOT_VALUE = RST_RX_FACTORY_TRIM_DEFAULT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Register port
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    // Configuration to receive datapath
    output sof_cfg_s sof_cfg_o,
    output demod_cfg_s demod_cfg_o,
    output corr_cfg_s corr_cfg_o,
    output logic [7:0] rx_factory_trim_o
);

    // ==========================================
    // Register storage
    logic [7:0] sof_pattern_high_r;
    logic [7:0] sof_pattern_low_r;
    logic [7:0] sof_sync_control_r;
    logic [7:0] rx_demod_control_r;
    logic [7:0] rx_correlator_config_r;
    logic [7:0] rx_factory_trim_r;
    logic trim_loaded_r;
    logic [7:0] reg_rdata_r;
    sof_cfg_s sof_cfg_r;
    demod_cfg_s demod_cfg_r;
    corr_cfg_s corr_cfg_r;

    // ==========================================
    // Address decode
    wire logic hit_high = (reg_addr_i == ADDR_SOF_PATTERN_HIGH);
    wire logic hit_low = (reg_addr_i == ADDR_SOF_PATTERN_LOW);
    wire logic hit_sync = (reg_addr_i == ADDR_SOF_SYNC_CONTROL);
    wire logic hit_demod = (reg_addr_i == ADDR_RX_DEMOD_CONTROL);
    wire logic hit_corr = (reg_addr_i == ADDR_RX_CORRELATOR_CONFIG);
    wire logic hit_trim = (reg_addr_i == ADDR_RX_FACTORY_TRIM);

    logic [7:0] read_mux;
    always_comb begin
        if (hit_high) begin
            read_mux = sof_pattern_high_r;
        end else if (hit_low) begin
            read_mux = sof_pattern_low_r;
        end else if (hit_sync) begin
            read_mux = sof_sync_control_r;
        end else if (hit_demod) begin
            read_mux = rx_demod_control_r & MASK_RX_DEMOD_CONTROL;
        end else if (hit_corr) begin
            read_mux = rx_correlator_config_r & MASK_RX_CORRELATOR_CONFIG;
        end else if (hit_trim) begin
            read_mux = rx_factory_trim_r;
        end else begin
            read_mux = 8'h00;
        end
    end

    // ==========================================
    // Field decode
    wire logic [15:0] pattern_value = {sof_pattern_high_r, sof_pattern_low_r};
    wire sof_pattern_kind_e pattern_kind = sof_pattern_kind_e'(sof_sync_control_r[SYNC_KIND_LSB +: 2]);

    // Nibble {data, coll}: data is bit 1, collision bit 0 of each nibble
    logic [3:0] nib_data;
    logic [3:0] nib_coll;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_nibble
            assign nib_coll[g] = pattern_value[4 * g];
            assign nib_data[g] = pattern_value[4 * g + 1] & ~nib_coll[g];
        end
    endgenerate

    function automatic subcarrier_e freq_decode(input logic [1:0] code);
        if (code == 2'd0) begin
            freq_decode = SUB_212K;
        end else if (code == 2'd1) begin
            freq_decode = SUB_424K;
        end else begin
            freq_decode = SUB_848K;
        end
    endfunction : freq_decode

    sof_cfg_s sof_cfg_nxt;
    demod_cfg_s demod_cfg_nxt;
    corr_cfg_s corr_cfg_nxt;

    always_comb begin
        sof_cfg_nxt.sof_pattern_value = pattern_value;
        sof_cfg_nxt.sof_valid_bit_count = sof_sync_control_r[SYNC_COUNT_LSB +: 4];
        sof_cfg_nxt.grid_from_first_falling_edge = sof_sync_control_r[SYNC_FALL_BIT];
        sof_cfg_nxt.final_sof_bit_half_length = sof_sync_control_r[SYNC_HALF_BIT];
        sof_cfg_nxt.sof_pattern_kind = pattern_kind;
        sof_cfg_nxt.burst_mode = (pattern_kind == KIND_BURST);
        sof_cfg_nxt.nibble_data = (pattern_kind == KIND_NIBBLE) ? nib_data : 4'h0;
        sof_cfg_nxt.nibble_collision = (pattern_kind == KIND_NIBBLE) ? nib_coll : 4'h0;
        sof_cfg_nxt.start_bit_resync = (pattern_kind == KIND_START_BIT);
        demod_cfg_nxt.four_sample_average = rx_demod_control_r[DEMOD_AVG_BIT];
        demod_cfg_nxt.square_shaping = rx_demod_control_r[DEMOD_SQUARE_BIT];
        demod_cfg_nxt.grid_at_peak = rx_demod_control_r[DEMOD_PEAK_BIT];
        demod_cfg_nxt.manchester_polarity = rx_demod_control_r[DEMOD_POL_BIT];
        demod_cfg_nxt.fsk_enable = rx_demod_control_r[DEMOD_FSK_BIT];
        demod_cfg_nxt.bpsk_enable = rx_demod_control_r[DEMOD_BPSK_BIT];
        corr_cfg_nxt.subcarrier_select = freq_decode(rx_correlator_config_r[CORR_FREQ_LSB +: 2]);
        corr_cfg_nxt.correlation_clock_count = corr_speed_e'(rx_correlator_config_r[CORR_SPEED_LSB +: 2]);
        corr_cfg_nxt.short_correlation_window = rx_correlator_config_r[CORR_SHORT_BIT];
        corr_cfg_nxt.correlation_length = rx_correlator_config_r[CORR_SHORT_BIT] ?
            CORR_LEN_SHORT : CORR_LEN_LONG;
    end

    // ==========================================
    // Register writes
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            sof_pattern_high_r <= RST_SOF_PATTERN_HIGH;
            sof_pattern_low_r <= RST_SOF_PATTERN_LOW;
            sof_sync_control_r <= RST_SOF_SYNC_CONTROL;
            rx_demod_control_r <= RST_RX_DEMOD_CONTROL;
            rx_correlator_config_r <= RST_RX_CORRELATOR_CONFIG;
        end else if (reg_write_i) begin
            if (hit_high) begin
                sof_pattern_high_r <= reg_wdata_i;
            end
            if (hit_low) begin
                sof_pattern_low_r <= reg_wdata_i;
            end
            if (hit_sync) begin
                sof_sync_control_r <= reg_wdata_i;
            end
            if (hit_demod) begin
                rx_demod_control_r <= reg_wdata_i & MASK_RX_DEMOD_CONTROL;
            end
            if (hit_corr) begin
                rx_correlator_config_r <= reg_wdata_i & MASK_RX_CORRELATOR_CONFIG;
            end
        end
    end

    // Factory trim: boot value loaded on first clock after reset release
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rx_factory_trim_r <= RST_RX_FACTORY_TRIM_DEFAULT;
            trim_loaded_r <= 1'b0;
        end else if (!trim_loaded_r) begin
            rx_factory_trim_r <= TRIM_BOOT_VALUE;
            trim_loaded_r <= 1'b1;
        end else if (reg_write_i && hit_trim) begin
            rx_factory_trim_r <= reg_wdata_i;
        end
    end

    // ==========================================
    // Read data and registered outputs
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_r <= 8'h00;
            sof_cfg_r <= '0;
            demod_cfg_r <= '0;
            corr_cfg_r <= '0;
        end else begin
            reg_rdata_r <= reg_read_i ? read_mux : 8'h00;
            sof_cfg_r <= sof_cfg_nxt;
            demod_cfg_r <= demod_cfg_nxt;
            corr_cfg_r <= corr_cfg_nxt;
        end
    end

    assign reg_rdata_o = reg_rdata_r;
    assign sof_cfg_o = sof_cfg_r;
    assign demod_cfg_o = demod_cfg_r;
    assign corr_cfg_o = corr_cfg_r;
    assign rx_factory_trim_o = rx_factory_trim_r;

endmodule : rx_sof_sync_correlator_config

`default_nettype wire

// ==== logic/rx_cfg_pkg.sv ====
package rx_cfg_pkg;

    // ==========================================
    // Register map
    localparam logic [6:0] ADDR_SOF_PATTERN_HIGH = 7'h5a;
    localparam logic [6:0] ADDR_SOF_PATTERN_LOW = 7'h5b;
    localparam logic [6:0] ADDR_SOF_SYNC_CONTROL = 7'h5c;
    localparam logic [6:0] ADDR_RX_DEMOD_CONTROL = 7'h5d;
    localparam logic [6:0] ADDR_RX_CORRELATOR_CONFIG = 7'h5e;
    localparam logic [6:0] ADDR_RX_FACTORY_TRIM = 7'h5f;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_SOF_PATTERN_HIGH = 8'h00;
    localparam logic [7:0] RST_SOF_PATTERN_LOW = 8'h00;
    localparam logic [7:0] RST_SOF_SYNC_CONTROL = 8'h00;
    localparam logic [7:0] RST_RX_DEMOD_CONTROL = 8'h00;
    localparam logic [7:0] RST_RX_CORRELATOR_CONFIG = 8'h00;
    localparam logic [7:0] RST_RX_FACTORY_TRIM_DEFAULT = 8'h00;

    // ==========================================
    // Writable bit masks
    localparam logic [7:0] MASK_RX_DEMOD_CONTROL = 8'h3f;
    localparam logic [7:0] MASK_RX_CORRELATOR_CONFIG = 8'hf8;

    // ==========================================
    // Field positions
    localparam int SYNC_COUNT_LSB = 4;
    localparam int SYNC_FALL_BIT = 3;
    localparam int SYNC_HALF_BIT = 2;
    localparam int SYNC_KIND_LSB = 0;
    localparam int DEMOD_AVG_BIT = 5;
    localparam int DEMOD_SQUARE_BIT = 4;
    localparam int DEMOD_PEAK_BIT = 3;
    localparam int DEMOD_POL_BIT = 2;
    localparam int DEMOD_FSK_BIT = 1;
    localparam int DEMOD_BPSK_BIT = 0;
    localparam int CORR_FREQ_LSB = 6;
    localparam int CORR_SPEED_LSB = 4;
    localparam int CORR_SHORT_BIT = 3;

    // ==========================================
    // Correlation window lengths
    localparam logic [6:0] CORR_LEN_LONG = 7'd64;
    localparam logic [6:0] CORR_LEN_SHORT = 7'd32;

    // ==========================================
    // Modes
    typedef enum logic [1:0] {
        KIND_BURST,
        KIND_NIBBLE,
        KIND_START_BIT,
        KIND_RESERVED
    } sof_pattern_kind_e;

    typedef enum logic [1:0] {
        SUB_212K,
        SUB_424K,
        SUB_848K
    } subcarrier_e;

    typedef enum logic [1:0] {
        SPEED_14443,
        SPEED_53K_424K,
        SPEED_26K_212K,
        SPEED_RESERVED
    } corr_speed_e;

    // ==========================================
    // Decoded configuration
    typedef struct packed {
        logic [15:0] sof_pattern_value;
        logic [3:0] sof_valid_bit_count;
        logic grid_from_first_falling_edge;
        logic final_sof_bit_half_length;
        sof_pattern_kind_e sof_pattern_kind;
        logic [3:0] nibble_data;
        logic [3:0] nibble_collision;
        logic burst_mode;
        logic start_bit_resync;
    } sof_cfg_s;

    typedef struct packed {
        logic four_sample_average;
        logic square_shaping;
        logic grid_at_peak;
        logic manchester_polarity;
        logic fsk_enable;
        logic bpsk_enable;
    } demod_cfg_s;

    typedef struct packed {
        subcarrier_e subcarrier_select;
        corr_speed_e correlation_clock_count;
        logic short_correlation_window;
        logic [6:0] correlation_length;
    } corr_cfg_s;

endpackage : rx_cfg_pkg

// ==== verif/rx_cfg_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module rx_cfg_assertions
    import rx_cfg_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    // Configuration outputs
    input wire sof_cfg_s sof_cfg_o,
    input wire demod_cfg_s demod_cfg_o,
    input wire corr_cfg_s corr_cfg_o,
    input wire logic [7:0] rx_factory_trim_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic [15:0] pv;
    logic [7:0] sync_v;
    assign pv = sof_cfg_o.sof_pattern_value;
    assign sync_v = {sof_cfg_o.sof_valid_bit_count, sof_cfg_o.grid_from_first_falling_edge,
                     sof_cfg_o.final_sof_bit_half_length, sof_cfg_o.sof_pattern_kind};
    // ==========================================
    // Write sequence
    sequence s_wr(logic [6:0] a);
        reg_write_i && reg_addr_i == a;
    endsequence
    // ==========================================
    // Properties
    property p_low;
        s_wr(ADDR_SOF_PATTERN_LOW) |-> ##2 pv[7:0] == $past(reg_wdata_i, 2);
    endproperty
    a_low: assert property (p_low) else $error("pattern low byte wrong");
    property p_high;
        s_wr(ADDR_SOF_PATTERN_HIGH) |-> ##2 pv[15:8] == $past(reg_wdata_i, 2);
    endproperty
    a_high: assert property (p_high) else $error("pattern high byte wrong");
    property p_sync;
        s_wr(ADDR_SOF_SYNC_CONTROL) |-> ##2 sync_v == $past(reg_wdata_i, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync control decode wrong");
    property p_demod;
        s_wr(ADDR_RX_DEMOD_CONTROL) |-> ##2 demod_cfg_o == 6'($past(reg_wdata_i, 2));
    endproperty
    a_demod: assert property (p_demod) else $error("demod decode wrong");
    property p_corr;
        s_wr(ADDR_RX_CORRELATOR_CONFIG) |-> ##2 corr_cfg_o.subcarrier_select ==
            ($past(reg_wdata_i, 2) >= 8'h80 ? 2'h2 : 2'($past(reg_wdata_i, 2) >> 6)) &&
            {corr_cfg_o.correlation_clock_count, corr_cfg_o.short_correlation_window} == 3'($past(reg_wdata_i, 2) >> 3);
    endproperty
    a_corr: assert property (p_corr) else $error("correlator decode wrong");
    property p_len;
        !$past(reset_i) |-> corr_cfg_o.correlation_length == (corr_cfg_o.short_correlation_window ? 7'h20 : 7'h40);
    endproperty
    a_len: assert property (p_len) else $error("correlation length wrong");
    property p_nib;
        sof_cfg_o.sof_pattern_kind == KIND_NIBBLE |-> sof_cfg_o.nibble_collision == {pv[12], pv[8], pv[4], pv[0]}
            && sof_cfg_o.nibble_data == ({pv[13], pv[9], pv[5], pv[1]} & ~sof_cfg_o.nibble_collision);
    endproperty
    a_nib: assert property (p_nib) else $error("nibble decode wrong");
    property p_kind;
        !$past(reset_i) |-> sof_cfg_o.burst_mode == (sof_cfg_o.sof_pattern_kind == KIND_BURST)
            && sof_cfg_o.start_bit_resync == (sof_cfg_o.sof_pattern_kind == KIND_START_BIT);
    endproperty
    a_kind: assert property (p_kind) else $error("pattern kind flags wrong");
endmodule : rx_cfg_assertions
bind rx_sof_sync_correlator_config rx_cfg_assertions u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .sof_cfg_o(sof_cfg_o), .demod_cfg_o(demod_cfg_o), .corr_cfg_o(corr_cfg_o),
    .rx_factory_trim_o(rx_factory_trim_o));
`default_nettype wire

// ==== verif/rx_sof_sync_correlator_config_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module rx_sof_sync_correlator_config_tb
    import rx_cfg_pkg::*;
;
    typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_s;
    localparam logic [7:0] TRIM_BOOT = 8'h3c; // Arbitrary value
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [6:0] reg_addr_i = 7'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [7:0] reg_rdata_o;
    sof_cfg_s sof_cfg_o;
    demod_cfg_s demod_cfg_o;
    corr_cfg_s corr_cfg_o;
    logic [7:0] rx_factory_trim_o;
    logic [7:0] rd;
    int mismatches = 0;
    int n_tests = 0;
    row_s rows [9] = '{'{7'h5a, 8'hff, 8'hff}, '{7'h5b, 8'ha5, 8'ha5}, '{7'h5c, 8'hff, 8'hff},
        '{7'h5d, 8'hff, 8'h3f}, '{7'h5e, 8'hff, 8'hf8}, '{7'h5f, 8'h5a, 8'h5a}, '{7'h40, 8'hff, 8'h00},
        '{7'h5d, 8'hc0, 8'h00}, '{7'h5e, 8'h07, 8'h00}};
    always #4 clk_sys_i = ~clk_sys_i;
    rx_sof_sync_correlator_config #(.TRIM_BOOT_VALUE(TRIM_BOOT)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .sof_cfg_o(sof_cfg_o), .demod_cfg_o(demod_cfg_o), .corr_cfg_o(corr_cfg_o),
        .rx_factory_trim_o(rx_factory_trim_o));
    // ==========================================
    // Bus tasks
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_write_i <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [6:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_read_i <= 1'b0;
        #1 rd = reg_rdata_o;
    endtask : rdr
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    // ==========================================
    // Sequence
    initial begin
        repeat (2000) @(posedge clk_sys_i);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        for (int i = 0; i < 6; i++) begin
            rdr(ADDR_SOF_PATTERN_HIGH + 7'(i));
            `CHK(rd, (i == 5) ? TRIM_BOOT : 8'h00)
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdr(rows[i].a);
            `CHK(rd, rows[i].e)
        end
        wr(ADDR_RX_DEMOD_CONTROL, 8'h2a);
        wr(ADDR_SOF_PATTERN_HIGH, 8'h31);
        wr(ADDR_SOF_PATTERN_LOW, 8'h23);
        wr(ADDR_SOF_SYNC_CONTROL, 8'hdd);
        rdr(ADDR_RX_DEMOD_CONTROL);
        `CHK(demod_cfg_o, 6'h2a)
        `CHK(sof_cfg_o.sof_pattern_value, 16'h3123)
        `CHK(sof_cfg_o.sof_valid_bit_count, 4'hd)
        `CHK({sof_cfg_o.grid_from_first_falling_edge, sof_cfg_o.final_sof_bit_half_length}, 2'h3)
        `CHK(sof_cfg_o.nibble_collision, 4'hd)
        `CHK(sof_cfg_o.nibble_data, 4'h2)
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_SOF_SYNC_CONTROL, 8'(k));
            wr(ADDR_RX_CORRELATOR_CONFIG, {2'(k), 2'(k), k[0], 3'h7});
            rdr(ADDR_RX_CORRELATOR_CONFIG);
            `CHK(rd, {2'(k), 2'(k), k[0], 3'h0})
            `CHK({sof_cfg_o.burst_mode, sof_cfg_o.start_bit_resync}, {k == 0, k == 2})
            `CHK(corr_cfg_o.subcarrier_select, (k > 1) ? 2'h2 : 2'(k))
            `CHK(corr_cfg_o.correlation_clock_count, 2'(k))
            `CHK(corr_cfg_o.correlation_length, k[0] ? 7'h20 : 7'h40)
        end
        // ==========================================
        // Idle read data, trim output and mid-run reset
        @(posedge clk_sys_i);
        #1 `CHK(reg_rdata_o, 8'h00)
        `CHK(rx_factory_trim_o, 8'h5a)
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 `CHK(demod_cfg_o, 6'h00)
        `CHK(corr_cfg_o.correlation_length, 7'h00)
        @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK(rx_factory_trim_o, TRIM_BOOT)
        `CHK(corr_cfg_o.correlation_length, 7'h40)
        rdr(ADDR_RX_DEMOD_CONTROL);
        `CHK(rd, 8'h00)
        stop_test();
    end
endmodule : rx_sof_sync_correlator_config_tb
`default_nettype wire
